// ### rtl/rad_top.sv
`timescale 1ns/1ps
module rad_top
#(
   parameter int unsigned WIDTH = rad_pkg::NUM_STAGES
)
(
   // system clock and reset
   input  wire logic             clock,
   input  wire logic             nrst,
   // capture clock pair and master reset pins
   input  wire logic             clk_true,
   input  wire logic             clk_comp,
   input  wire logic             mrst_n,
   // address and control word in, registered copy out
   input  wire logic [WIDTH-1:0] capture_inputs,
   output      logic [WIDTH-1:0] registered_outputs
);

   rad_pkg::rad_pins_t  pins_raw;
   rad_pkg::rad_pins_t  pins_s;
   rad_pkg::rad_state_t st_r;
   rad_pkg::rad_state_t st_nxt;
   logic                capture_edge;

   // the state struct is sized from the package, so the width cannot float
   initial
   begin
      if (WIDTH != rad_pkg::NUM_STAGES)
         $error("rad_top: WIDTH must equal the bank size");
   end

   // every pin crosses two flip-flops before use
   always_comb
   begin
      pins_raw          = '0;
      pins_raw.mrst_n   = mrst_n;
      pins_raw.clk_comp = clk_comp;
      pins_raw.clk_true = clk_true;
      pins_raw.data     = capture_inputs;
   end

   rad_sync
   #(
      .WIDTH (rad_pkg::PINS_W)
   )
   u_sync
   (
      .clock    (clock),
      .nrst     (nrst),
      .pin_in   (pins_raw),
      .pin_sync (pins_s)
   );

   // true rising together with complement falling; one alone is noise
   assign capture_edge = pins_s.clk_true && !st_r.true_prev &&
                         !pins_s.clk_comp && st_r.comp_prev;

   // stage bank update
   always_comb
   begin
      st_nxt           = st_r;
      st_nxt.true_prev = pins_s.clk_true;
      st_nxt.comp_prev = pins_s.clk_comp;
      st_nxt.data_prev = pins_s.data;
      if (!pins_s.mrst_n)
      begin
         // reset needs no capture edge and beats any edge or data
         st_nxt.stages = rad_pkg::STAGE_RST;
      end
      else if (capture_edge)
      begin
         // data sampled alongside the pre-edge clock level, so hold is kept
         st_nxt.stages = st_r.data_prev;
      end
      else
      begin
         // no edge: every stage keeps its value, zero included after reset
         st_nxt.stages = st_r.stages;
      end
   end

   // single state register
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         st_r.true_prev <= rad_pkg::PAIR_RST;
         st_r.comp_prev <= rad_pkg::PAIR_RST;
         st_r.data_prev <= rad_pkg::STAGE_RST;
         st_r.stages    <= rad_pkg::STAGE_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // each stage drives exactly one output bit
   assign registered_outputs = st_r.stages;

endmodule

// ### inc/rad_pkg.sv
package rad_pkg;

   // bank geometry
   localparam int unsigned NUM_STAGES = 14;
   localparam int unsigned SYNC_DEPTH = 2;

   // reset values
   localparam logic [NUM_STAGES-1:0] STAGE_RST = 14'h0000;
   localparam logic                  PAIR_RST  = 1'h0;

   // sampled pin group: master reset, clock pair, data word
   typedef struct packed {
      logic                  mrst_n;
      logic                  clk_comp;
      logic                  clk_true;
      logic [NUM_STAGES-1:0] data;
   } rad_pins_t;

   localparam int unsigned PINS_W = $bits(rad_pins_t);

   // whole state of the driver core
   typedef struct packed {
      logic                  true_prev;
      logic                  comp_prev;
      logic [NUM_STAGES-1:0] data_prev;
      logic [NUM_STAGES-1:0] stages;
   } rad_state_t;

endpackage

// ### rtl/rad_sync.sv
`timescale 1ns/1ps
module rad_sync
#(
   parameter int unsigned WIDTH = 1
)
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             nrst,
   // asynchronous pins in, resynchronised copy out
   input  wire logic [WIDTH-1:0] pin_in,
   output      logic [WIDTH-1:0] pin_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] safe;
   } rad_sync_state_t;

   rad_sync_state_t st_r;
   rad_sync_state_t st_nxt;

   initial
   begin
      if (WIDTH < 1)
         $error("rad_sync: WIDTH must be at least one");
   end

   // first stage feeds only the second stage; nothing else looks at it
   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.meta = pin_in;
      st_nxt.safe = st_r.meta;
   end

   // reset to low: a held-low master reset pin then reads as asserted
   always_ff @(posedge clock)
   begin
      if (!nrst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign pin_sync = st_r.safe;

endmodule

// ### dv/rad_checker.sv
`timescale 1ns/1ps
module rad_checker
(
   // top module pins
   input logic        clock,
   input logic        nrst,
   input logic        clk_true,
   input logic        clk_comp,
   input logic        mrst_n,
   input logic [13:0] capture_inputs,
   input logic [13:0] registered_outputs
);
   // two sync flops and the stage register put three edges of lag on the clock pair and reset pins; the data word has four
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   a_word_load: assert property (
      mrst_n [*3] ##0 ($rose(clk_true) && $fell(clk_comp)) |->
      ##3 registered_outputs == $past(capture_inputs, 3)) else $error("load");
   a_hold_idle: assert property (
      mrst_n && !$fell(clk_comp) |-> ##3 $stable(registered_outputs)) else $error("hold");
   a_reset_clear: assert property (
      !mrst_n [*3] |=> registered_outputs == '0) else $error("clear");
   // a held reset keeps the bank low whatever the pair and data do
   a_reset_hold: assert property (
      !mrst_n [*4] |-> registered_outputs == '0) else $error("reset hold");
   a_release_zero: assert property (
      !mrst_n [*4] ##1 mrst_n [*3] |-> registered_outputs == '0) else $error("release");
   c_load: cover property ($rose(clk_true) && $fell(clk_comp));
   c_lone: cover property ($rose(clk_true) && $stable(clk_comp));
   c_reset: cover property ($fell(mrst_n));
endmodule
bind rad_top rad_checker u_rad_checker (.*);

// ### dv/rad_ctl.sv
`timescale 1ns/1ps
module rad_ctl
(
   // pins toward the driver
   input  logic        clock,
   output logic        clk_true,
   output logic        clk_comp,
   output logic        mrst_n,
   output logic [13:0] capture_inputs
);
   // reset low and pair idle until the first frame
   initial {mrst_n, clk_true, clk_comp, capture_inputs} = 17'h04000;
   task cap(logic [13:0] w, logic ok, logic r);
      {mrst_n, capture_inputs} <= {r, w};
      repeat (4) @(posedge clock);
      {clk_true, clk_comp} <= {1'h1, !ok};
      repeat (4) @(posedge clock);
      {clk_true, clk_comp} <= 2'h1;
   endtask
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
   logic        clock = 1'h0;
   logic        nrst = 1'h0;
   logic        clk_true, clk_comp, mrst_n;
   logic [13:0] capture_inputs, q;
   int          fails = 0, checked = 0;
   // system clock
   always #5 clock = !clock;
   rad_top u_rad_top (.*, .registered_outputs(q));
   rad_ctl u_rad_ctl (.*);
   task cmp(logic [13:0] s, logic [13:0] e);
      checked++;
      fails += (s !== e);
      if (s !== e)
         $display("[ERR] q exp %h seen %h", e, s);
   endtask
   task test_done();
      if (fails == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task t_cap();
      u_rad_ctl.cap(14'h2a5c, 1'h1, 1'h1);
      cmp(q, 14'h2a5c);
      u_rad_ctl.cap(14'h15a3, 1'h0, 1'h1);
      cmp(q, 14'h2a5c);
   endtask
   task t_mrst();
      u_rad_ctl.cap(14'h3fff, 1'h1, 1'h0);
      cmp(q, 14'h0000);
      u_rad_ctl.cap(14'h1234, 1'h0, 1'h1);
      cmp(q, 14'h0000);
   endtask
   initial
   begin
      repeat (2) @(posedge clock);
      nrst <= 1'h1;
      t_cap();
      t_mrst();
      test_done();
   end
endmodule
